//--- hdl/codec_ctrl_pkg.sv
// Package: register map, field layout and reset values of the codec control bank
package codec_ctrl_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RESET_IDENT = 8'h00;
   localparam logic [7:0] IDX_REVISION    = 8'h01;
   localparam logic [7:0] IDX_BIAS        = 8'h04;
   localparam logic [7:0] IDX_REFBUF      = 8'h05;
   localparam int         ADDR_LSB        = 2;    // Word aligned
   localparam int         IDX_W           = 8;    // Index width

   // Identity values, arbitrary neutral codes
   localparam logic [15:0] DEVICE_IDENT_DEFAULT = 16'h5A01; // Arbitrary
   localparam logic [3:0]  REVISION_DEFAULT     = 4'h1;     // Arbitrary

   // Bias control field positions
   localparam int BIAS_SRC_BIT   = 4;
   localparam int BIAS_LVL_HI    = 3;
   localparam int BIAS_LVL_LO    = 2;
   localparam int BIAS_STARTUP   = 1;
   localparam int BIAS_NORMAL    = 0;
   // Reference buffer control field positions
   localparam int REF_TIE_BIT    = 7;
   localparam int REF_UNUSED_BIT = 6;
   localparam int REF_ALIAS_BIT  = 5;

   // Master bias level codes
   typedef enum logic [1:0]
   {
      BIAS_HALF       = 2'b00,
      BIAS_THREE_QTR  = 2'b01,
      BIAS_NOMINAL    = 2'b10,
      BIAS_ONE_HALF   = 2'b11
   } bias_level_e;

   // Reset values of the writable fields
   localparam logic        SRC_SEL_RESET  = 1'b1;
   localparam bias_level_e LEVEL_RESET    = BIAS_NOMINAL;
   localparam logic        ENABLE_RESET   = 1'b0;

   // Analogue control outputs carried together
   typedef struct packed
   {
      logic        output_bias_source_sel; // 1 = start-up bias
      bias_level_e master_bias_level;      // Master bias scale
      logic        startup_generator_on;   // Effective start-up enable
      logic        normal_generator_on;    // Normal bias generator
      logic        ref_tie_lineouts;       // Effective tie, outputs off
      logic        ref_to_unused_pins;     // Buffer to unused pins
   } analog_ctrl_s;
endpackage

//--- hdl/codec_reset_id_bias_registers.sv
// Module: APB register bank for soft reset, identity, revision and bias
`timescale 1ns/1ps

// Overview of operation
// RULE_01: Any write at offset zero restores defaults.
// RULE_02: Offset zero reads the fixed identity code.
// RULE_03: Revision register reads four bits, ignores writes.
// RULE_04: Bias bit 4 selects output bias source.
// RULE_05: Bias bits 3:2 set master level.
// RULE_06: Bias bit 1 enables start-up generator.
// RULE_07: Bias bit 0 enables normal generator.
// RULE_08: Reference tie applies only with outputs off.
// RULE_09: Reference bit 6 feeds unused pins.
// RULE_10: Reference bit 5 also enables start-up generator.
// RULE_11: Undefined bits read zero; reset ignores data.
module codec_reset_id_bias_registers
#(
   parameter logic [15:0] DEVICE_IDENT = codec_ctrl_pkg::DEVICE_IDENT_DEFAULT,
   parameter logic [3:0]  REVISION     = codec_ctrl_pkg::REVISION_DEFAULT
)
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output      logic [31:0]                 prdata,
   output      logic                        pready,
   output      logic                        pslverr,
   input  wire logic                        left_diff_out_on,
   input  wire logic                        right_diff_out_on,
   output      codec_ctrl_pkg::analog_ctrl_s analog_ctrl
);
   import codec_ctrl_pkg::*;

   // Stored fields of the writable registers
   logic        src_sel;        // Bias source select
   bias_level_e level;          // Master bias level
   logic        startup_en;     // Start-up generator bit
   logic        normal_en;      // Normal generator bit
   logic        tie_en;         // Reference tie request
   logic        unused_en;      // Reference to unused pins
   logic        alias_en;       // Start-up generator alias bit
   logic        next_src_sel;
   bias_level_e next_level;
   logic        next_startup_en;
   logic        next_normal_en;
   logic        next_tie_en;
   logic        next_unused_en;
   logic        next_alias_en;
   logic [31:0] next_prdata;    // Read data for the completing edge
   logic        next_pslverr;   // Error for the completing edge
   logic        wait_done;      // First access cycle has passed
   logic        next_wait_done;

   // Decode helpers
   logic             access;    // Access phase, completes at the edge that finds wait_done high
   logic [IDX_W-1:0] idx;       // Register index from byte address
   logic             aligned;   // Low address bits and bits above the index clear
   logic             mapped;    // Address hits a register

   // Pin levels from the output stage, outside our clock domain
   logic [1:0] out_meta;        // First stage, read only by second
   logic [1:0] out_sync;        // Synchronised enables

   // One wait state: the answer is registered in the first access cycle,
   // so read data and error stand in flops when pready is sampled high
   assign pready = wait_done;
   assign access = psel && penable;
   assign idx = paddr[ADDR_LSB +: IDX_W];
   assign aligned = (paddr[ADDR_LSB-1:0] == '0)
                 && (paddr[31:ADDR_LSB+IDX_W] == '0);

   // Address decoding
   always_comb
   begin
      if (!aligned)
      begin
         mapped = 1'b0;
      end
      else if (idx == IDX_RESET_IDENT || idx == IDX_REVISION)
      begin
         mapped = 1'b1;
      end
      else if (idx == IDX_BIAS || idx == IDX_REFBUF)
      begin
         mapped = 1'b1;
      end
      else
      begin
         mapped = 1'b0;
      end
   end

   // Next values of fields, read data and error
   always_comb
   begin
      next_src_sel    = src_sel;
      next_level      = level;
      next_startup_en = startup_en;
      next_normal_en  = normal_en;
      next_tie_en     = tie_en;
      next_unused_en  = unused_en;
      next_alias_en   = alias_en;
      next_prdata     = '0;
      next_pslverr    = access && !wait_done && !mapped;
      next_wait_done  = access && !wait_done;
      // Writes land only at the edge that completes the transfer
      if (access && wait_done && mapped && pwrite)
      begin
         // Low byte lane holds every writable field
         if (idx == IDX_RESET_IDENT)
         begin
            // Data and strobes do not matter, all fields reload
            next_src_sel    = SRC_SEL_RESET; // RULE_01 RULE_11
            next_level      = LEVEL_RESET;   // RULE_01
            next_startup_en = ENABLE_RESET;  // RULE_01
            next_normal_en  = ENABLE_RESET;  // RULE_01
            next_tie_en     = ENABLE_RESET;  // RULE_01
            next_unused_en  = ENABLE_RESET;  // RULE_01
            next_alias_en   = ENABLE_RESET;  // RULE_01
         end
         else if (idx == IDX_BIAS && pstrb[0])
         begin
            next_src_sel    = pwdata[BIAS_SRC_BIT]; // RULE_04
            next_level      =
               bias_level_e'(pwdata[BIAS_LVL_HI:BIAS_LVL_LO]); // RULE_05
            next_startup_en = pwdata[BIAS_STARTUP];                 // RULE_06
            next_normal_en  = pwdata[BIAS_NORMAL];                  // RULE_07
         end
         else if (idx == IDX_REFBUF && pstrb[0])
         begin
            next_tie_en    = pwdata[REF_TIE_BIT];    // RULE_08
            next_unused_en = pwdata[REF_UNUSED_BIT]; // RULE_09
            next_alias_en  = pwdata[REF_ALIAS_BIT];  // RULE_10
         end
         // Revision writes fall through untouched
      end
      else if (access && !wait_done && mapped && !pwrite)
      begin
         // Reads: undefined bits stay zero
         if (idx == IDX_RESET_IDENT)
         begin
            next_prdata[15:0] = DEVICE_IDENT; // RULE_02 RULE_11
         end
         else if (idx == IDX_REVISION)
         begin
            next_prdata[3:0] = REVISION;      // RULE_03
         end
         else if (idx == IDX_BIAS)
         begin
            next_prdata[BIAS_SRC_BIT]             = src_sel;
            next_prdata[BIAS_LVL_HI:BIAS_LVL_LO]  = level;
            next_prdata[BIAS_STARTUP]             = startup_en;
            next_prdata[BIAS_NORMAL]              = normal_en;
         end
         else
         begin
            next_prdata[REF_TIE_BIT]    = tie_en;
            next_prdata[REF_UNUSED_BIT] = unused_en;
            next_prdata[REF_ALIAS_BIT]  = alias_en;
         end
      end
   end

   // Register the fields and the bus answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_sel    <= SRC_SEL_RESET;
         level      <= LEVEL_RESET;
         startup_en <= ENABLE_RESET;
         normal_en  <= ENABLE_RESET;
         tie_en     <= ENABLE_RESET;
         unused_en  <= ENABLE_RESET;
         alias_en   <= ENABLE_RESET;
         prdata     <= '0;
         pslverr    <= 1'b0;
         wait_done  <= 1'b0;
      end
      else
      begin
         src_sel    <= next_src_sel;
         level      <= next_level;
         startup_en <= next_startup_en;
         normal_en  <= next_normal_en;
         tie_en     <= next_tie_en;
         unused_en  <= next_unused_en;
         alias_en   <= next_alias_en;
         prdata     <= next_prdata;
         pslverr    <= next_pslverr;
         wait_done  <= next_wait_done;
      end
   end

   // Two-stage synchroniser for the output-stage enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_meta <= '0;
         out_sync <= '0;
      end
      else
      begin
         out_meta <= {right_diff_out_on, left_diff_out_on};
         out_sync <= out_meta;
      end
   end

   // Effective analogue controls, registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         analog_ctrl <= '{SRC_SEL_RESET, LEVEL_RESET, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      else
      begin
         analog_ctrl.output_bias_source_sel <= src_sel;            // RULE_04
         analog_ctrl.master_bias_level      <= level;              // RULE_05
         // Either enable bit turns the start-up generator on
         analog_ctrl.startup_generator_on   <=
            startup_en | alias_en; // RULE_06 RULE_10
         analog_ctrl.normal_generator_on    <= normal_en;          // RULE_07
         // Tie held off while either differential output is on
         analog_ctrl.ref_tie_lineouts       <=
            tie_en & ~(|out_sync); // RULE_08
         analog_ctrl.ref_to_unused_pins     <= unused_en;          // RULE_09
      end
   end
endmodule

//--- sim/codec_regs_sva.sv
// Checker: assertions on the codec control bank ports
`timescale 1ns/1ps
module codec_regs_sva
#(
   parameter logic [15:0] DEVICE_IDENT = 16'h0000,
   parameter logic [3:0]  REVISION     = 4'h0
)
(
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [31:0]                  paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [3:0]                   pstrb,
   input wire logic [31:0]                  prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input wire logic                         left_diff_out_on,
   input wire logic                         right_diff_out_on,
   input wire codec_ctrl_pkg::analog_ctrl_s analog_ctrl
);
   import codec_ctrl_pkg::*;
   // Completed transfer and decode of the four mapped words
   logic acc;
   logic hit;
   assign acc = psel & penable & pready;
   assign hit = paddr inside {32'h00, 32'h04, 32'h10, 32'h14};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ident_read:
      assert property (acc && !pwrite && paddr == 32'h0
         |-> prdata == {16'h0, DEVICE_IDENT}) else $error("bad ident");
   a_rev_read:
      assert property (acc && !pwrite && paddr == 32'h4
         |-> prdata == {28'h0, REVISION}) else $error("bad revision");
   a_soft_reset:
      assert property (acc && pwrite && paddr == 32'h0
         |-> ##2 analog_ctrl == {1'b1, BIAS_NOMINAL, 4'h0})
         else $error("defaults not restored");
   a_bias_level:
      assert property (acc && pwrite && pstrb[0] && paddr == 32'h10
         |-> ##2 analog_ctrl.master_bias_level == $past(pwdata[3:2], 2))
         else $error("bias level not applied");
   a_err_unmapped:
      assert property (acc && !hit |-> pslverr) else $error("no error");
   a_err_mapped:
      assert property (acc && hit |-> !pslverr) else $error("false error");
   a_tie_held_off:
      assert property ((left_diff_out_on || right_diff_out_on)[*4]
         |-> !analog_ctrl.ref_tie_lineouts) else $error("tie while on");
   a_bias_upper:
      assert property (acc && !pwrite && paddr == 32'h10
         |-> prdata[31:5] == 27'h0) else $error("undefined bits set");
   c_soft_reset: cover property (acc && pwrite && paddr == 32'h0);
   c_unmapped: cover property (acc && !hit);
   c_tie: cover property (analog_ctrl.ref_tie_lineouts);
endmodule

//--- sim/codec_reset_id_bias_registers_tb_top.sv
// Testbench: directed checks of the codec control register bank
`timescale 1ns/1ps
module codec_reset_id_bias_registers_tb_top;
   import codec_ctrl_pkg::*;
   logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic         left_diff_out_on = 0, right_diff_out_on = 0;
   logic         pready, pslverr, err;
   logic [31:0]  paddr = 0, pwdata = 0, prdata, rd;
   logic [3:0]   pstrb = 0;
   analog_ctrl_s analog_ctrl;
   int           miscompares = 0, cmp_count = 0;
   // 10 MHz control clock
   always #50 pclk = ~pclk;
   codec_reset_id_bias_registers dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .left_diff_out_on(left_diff_out_on),
      .right_diff_out_on(right_diff_out_on), .analog_ctrl(analog_ctrl)
   );
   // Four-state compare so an unknown never passes
   task automatic chk(input logic [31:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [31:0] a, d,
                      input logic [3:0] s);
      int   n;
      logic rdy;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer read where settled; it stands up to the completing edge
      do
      begin
         @(negedge pclk);
         rdy = pready;
         rd  = prdata;
         err = pslverr;
         @(posedge pclk);
         n++;
      end
      while (rdy !== 1'b1 && n < 16);
      if (rdy !== 1'b1)
      begin
         miscompares++;
         $display("unexpected at %0t: pready never seen", $time);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [31:0] a, exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rd, exp, "read");
   endtask
   // Writes need two edges, pin levels three (two sync flops)
   task automatic ana(input logic [6:0] exp);
      repeat (3) @(posedge pclk);
      #1;
      chk({25'h0, analog_ctrl}, {25'h0, exp}, "analog");
   endtask
   task automatic t_defaults();
      rdchk(32'h10, 32'h18);
      rdchk(32'h14, 32'h00);
      ana(7'h60);
      $display("defaults done");
   endtask
   task automatic t_ident();
      rdchk(32'h0, {16'h0, DEVICE_IDENT_DEFAULT});
      apb(1'b1, 32'h4, 32'hFFFFFFFF, 4'hF);
      rdchk(32'h4, {28'h0, REVISION_DEFAULT});
      $display("ident done");
   endtask
   task automatic t_bias();
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, 32'h10, 32'hFFFFFFE1 | (i << 2), 4'hF);
         rdchk(32'h10, 32'h01 | (i << 2));
         ana(7'(i << 4) | 7'h04);
      end
      apb(1'b1, 32'h10, 32'h0, 4'h0);
      rdchk(32'h10, 32'h0D);
      $display("bias done");
   endtask
   task automatic t_ref();
      apb(1'b1, 32'h10, 32'h0, 4'hF);
      apb(1'b1, 32'h14, 32'hFFFFFFFF, 4'hF);
      rdchk(32'h14, 32'hE0);
      ana(7'h0B);
      left_diff_out_on <= 1'b1;
      ana(7'h09);
      left_diff_out_on  <= 1'b0;
      right_diff_out_on <= 1'b1;
      ana(7'h09);
      right_diff_out_on <= 1'b0;
      ana(7'h0B);
      $display("reference done");
   endtask
   task automatic t_soft_reset();
      apb(1'b1, 32'h0, 32'h0, 4'h0);
      rdchk(32'h10, 32'h18);
      rdchk(32'h14, 32'h00);
      ana(7'h60);
      $display("soft reset done");
   endtask
   task automatic t_unmapped();
      apb(1'b0, 32'h8, 32'h0, 4'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      apb(1'b1, 32'h12, 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1, "misaligned");
      rdchk(32'h10, 32'h18);
      chk({31'h0, err}, 32'h0, "mapped");
      $display("unmapped done");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence after a 20 cycle reset
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_ident();
      t_bias();
      t_ref();
      t_soft_reset();
      t_unmapped();
      give_verdict();
   end
   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #200us;
      miscompares++;
      give_verdict();
   end
endmodule
bind codec_reset_id_bias_registers codec_regs_sva
   #(.DEVICE_IDENT(DEVICE_IDENT), .REVISION(REVISION)) u_sva
   (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .left_diff_out_on(left_diff_out_on),
    .right_diff_out_on(right_diff_out_on), .analog_ctrl(analog_ctrl));
